/* acm_readout.sv */
// Top of the accelerometer serial readout: frame, conversion, output
`timescale 1ns/1ns
module acm_readout #(
  parameter int unsigned DW = acm_pkg::DATA_W
) (
  // System clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // Serial link pins
  input  wire logic          sclk,
  input  wire logic          accel_select_n,
  input  wire logic          temp_select_n,
  input  wire logic          din,
  output logic               dout,
  output logic               dout_oe,
  // Sensor front end
  input  wire logic [DW-1:0] accel_x,
  input  wire logic [DW-1:0] accel_y,
  input  wire logic          self_test_in,
  // Status
  output logic               power_down
);
  import acm_pkg::*;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  // Rising-edge frame state on the serial clock
  typedef struct packed {
    logic [EDGE_W-1:0] edge_cnt;   // Rises seen in this conversion
    logic              req_tgl;    // Sample request toggle
    logic              armed;      // A sample was asked for this time
  } acm_rise_t;

  // Falling-edge output state on the serial clock
  typedef struct packed {
    logic dout;
  } acm_fall_t;

  // System clock state
  typedef struct packed {
    logic          oe;             // Output driver enable
    logic          done_tgl;       // Sample answer toggle
    logic [DW-1:0] word;           // Held conversion result
    logic          link_rst;       // Clears link-side mode register
    logic          pdown;          // Shutdown status
  } acm_sys_t;

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  acm_rise_t rise_q;               // Link rise state
  acm_rise_t rise_d;
  acm_fall_t fall_q;               // Link fall state
  acm_fall_t fall_d;
  acm_sys_t  sys_q;                // System state
  acm_sys_t  sys_d;

  logic          cs_s;             // Accel select, synced
  logic          tcs_s;            // Temperature select, synced
  logic          st_s;             // Self-test, synced
  logic          req_s;            // Request toggle, synced
  logic          axis_s;           // Axis choice, synced
  logic          pm_s;             // Shutdown, synced
  logic          done_s;           // Answer toggle, on serial clock
  logic          capture;          // System takes a sample now
  logic [DW-1:0] samp_sel;         // Chosen axis with self-test shift

  acm_ctl_if cif ();

  // ---------------------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------------------
  // Pins and link levels into the system clock
  // Axis and mode change rarely, so a plain pair of flops will do
  acm_sync #(.W(6)) u_sync_sys (
    .clk (clock),
    .d   ({accel_select_n, temp_select_n, self_test_in,
           rise_q.req_tgl, cif.axis, cif.pm}),
    .q   ({cs_s, tcs_s, st_s, req_s, axis_s, pm_s})
  );

  // Answer toggle back to the serial clock
  acm_sync #(.W(1)) u_sync_link (
    .clk (sclk),
    .d   (sys_q.done_tgl),
    .q   (done_s)
  );

  // ---------------------------------------------------------------------
  // Control shifter
  // ---------------------------------------------------------------------
  assign cif.edge_idx = rise_q.edge_cnt;
  assign cif.din      = din;

  acm_ctrl_shift u_ctrl (
    .sclk     (sclk),
    .link_clr (sys_q.link_rst),
    .cif      (cif)
  );

  // ---------------------------------------------------------------------
  // Link rise logic
  // ---------------------------------------------------------------------
  // The serial clock itself paces the conversion; no other clock here
  always_comb begin
    rise_d = rise_q;
    // Wrap after sixteen rises and go straight on
    if (rise_q.edge_cnt == EDGE_LAST) begin
      rise_d.edge_cnt = '0;
    end else begin
      rise_d.edge_cnt = rise_q.edge_cnt + 1'b1;
    end
    // Ask for a sample on the second rise unless shut down
    if (rise_q.edge_cnt == EDGE_SAMPLE) begin
      // Shutdown skips the sample; that conversion then stays quiet
      rise_d.armed = !cif.pm;
      if (!cif.pm) begin
        rise_d.req_tgl = ~rise_q.req_tgl;
      end
    end
  end

  // Select high holds the frame idle; the clock may be stopped then
  always_ff @(posedge sclk or posedge accel_select_n) begin
    if (accel_select_n) begin
      rise_q <= '{edge_cnt: '0, req_tgl: 1'b0,
                  armed: 1'b0};
    end else begin
      rise_q <= rise_d;
    end
  end

  // ---------------------------------------------------------------------
  // Link fall logic
  // ---------------------------------------------------------------------
  // Leading zeros, then the result MSB first once the answer is in
  always_comb begin
    int unsigned k;
    int unsigned pos;
    k      = 0;
    pos    = 0;
    fall_d = fall_q;
    // Index of the rise that preceded this fall
    k = int'(rise_q.edge_cnt) + FRAME_EDGES - 1;
    k = k % FRAME_EDGES;
    fall_d.dout = 1'b0;
    // A wake-up conversion asked for nothing, so its bits stay low
    if (k >= LEAD_BITS && rise_q.armed && done_s == rise_q.req_tgl &&
        !cif.pm) begin
      // Word is held by the system until the next request
      pos = DW - 1 - (k - LEAD_BITS);
      fall_d.dout = sys_q.word[pos[$clog2(DW)-1:0]];
    end
  end

  // Bits change on the falling edge; select high clears them at once
  always_ff @(negedge sclk or posedge accel_select_n) begin
    if (accel_select_n) begin
      fall_q <= '{dout: DOUT_RST};
    end else begin
      fall_q <= fall_d;
    end
  end

  // ---------------------------------------------------------------------
  // System side
  // ---------------------------------------------------------------------
  // A changed request toggle means the link wants a new sample
  // Limitation: the sample lands a few system clocks after the rise
  assign capture = (req_s != sys_q.done_tgl) && !cs_s;

  // Chosen axis plus optional self-test shift, wrapping at the width
  always_comb begin
    samp_sel = axis_s ? accel_y : accel_x;
    if (st_s) begin
      samp_sel = DW'(samp_sel + DW'(ST_SHIFT_LSB));
    end
  end

  // System next state
  always_comb begin
    sys_d          = sys_q;
    sys_d.link_rst = 1'b0;
    sys_d.pdown    = pm_s;
    // Drive only for an accel frame; temperature owns the line else
    sys_d.oe       = !cs_s && tcs_s;
    if (cs_s) begin
      // Idle frame: match the link side, which clears its toggle
      sys_d.done_tgl = 1'b0;
    end else if (capture) begin
      sys_d.word     = samp_sel;
      sys_d.done_tgl = req_s;
    end
  end

  // System registers; link clear held through reset
  // The link clear is a register, so it never glitches the link flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sys_q <= '{oe: OE_RST, done_tgl: 1'b0, word: '0,
                 link_rst: 1'b1, pdown: PM_RST};
    end else begin
      sys_q <= sys_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // All three come straight from flops, no gates after them
  assign dout       = fall_q.dout;
  assign dout_oe    = sys_q.oe;
  assign power_down = sys_q.pdown;

  // ---------------------------------------------------------------------
  // Assertions, system clock
  // ---------------------------------------------------------------------
  // Release bound in system clocks
  localparam int REL_MAX = RELEASE_CYC;

  property p_release;
    @(posedge clock) disable iff (!nrst)
      $rose(accel_select_n) |-> ##[1:REL_MAX] !dout_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released after select rise");

  property p_drive;
    @(posedge clock) disable iff (!nrst)
      $fell(cs_s) && tcs_s |=> dout_oe;
  endproperty
  a_drive: assert property (p_drive)
    else $error("output not driven after select fall");

  property p_temp_owns;
    @(posedge clock) disable iff (!nrst)
      !tcs_s |=> !dout_oe;
  endproperty
  a_temp_owns: assert property (p_temp_owns)
    else $error("accel path drove during temperature frame");

  // Select high drops the driver on the next edge
  property p_oe_idle;
    @(posedge clock) disable iff (!nrst)
      cs_s |=> !dout_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output still driven with select high");

  property p_selftest;
    @(posedge clock) disable iff (!nrst)
      capture && st_s && !axis_s |=>
        sys_q.word == DW'($past(accel_x) + DW'(ST_SHIFT_LSB));
  endproperty
  a_selftest: assert property (p_selftest)
    else $error("self-test shift missing");

  property p_axis_y;
    @(posedge clock) disable iff (!nrst)
      capture && axis_s && !st_s |=> sys_q.word == $past(accel_y);
  endproperty
  a_axis_y: assert property (p_axis_y)
    else $error("y axis not selected");

  // ---------------------------------------------------------------------
  // Assertions, serial clock
  // ---------------------------------------------------------------------
  property p_wrap;
    @(posedge sclk) disable iff (accel_select_n)
      rise_q.edge_cnt == EDGE_LAST |=> rise_q.edge_cnt == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("conversion not sixteen rises");

  property p_sample;
    @(posedge sclk) disable iff (accel_select_n)
      rise_q.edge_cnt == EDGE_SAMPLE && !cif.pm |=> $changed(rise_q.req_tgl);
  endproperty
  a_sample: assert property (p_sample)
    else $error("no sample on second rise");

  property p_restart;
    @(posedge sclk) disable iff (accel_select_n)
      rise_q.edge_cnt == EDGE_LAST && !cif.pm ##2 !cif.pm
        |=> $changed(rise_q.req_tgl);
  endproperty
  a_restart: assert property (p_restart)
    else $error("held select did not restart conversion");

  property p_lead_zero;
    @(negedge sclk) disable iff (accel_select_n)
      rise_q.edge_cnt >= 1 && rise_q.edge_cnt <= LEAD_BITS |=> !dout;
  endproperty
  a_lead_zero: assert property (p_lead_zero)
    else $error("leading bit not zero");

  // Shutdown keeps the data line low from the next fall on
  property p_shut_quiet;
    @(negedge sclk) disable iff (accel_select_n)
      cif.pm |=> !dout;
  endproperty
  a_shut_quiet: assert property (p_shut_quiet)
    else $error("data driven high in shutdown");

  // A conversion with no sample sends only zeros
  property p_unarmed_quiet;
    @(negedge sclk) disable iff (accel_select_n)
      !rise_q.armed |=> !dout;
  endproperty
  a_unarmed_quiet: assert property (p_unarmed_quiet)
    else $error("stale bit sent in a conversion with no sample");

  // ---------------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------------
  property p_cv_two_conv;
    @(posedge sclk) disable iff (accel_select_n)
      rise_q.edge_cnt == EDGE_LAST ##3 $changed(rise_q.req_tgl);
  endproperty
  c_two_conv: cover property (p_cv_two_conv);

  property p_cv_st_capture;
    @(posedge clock) disable iff (!nrst)
      capture && st_s;
  endproperty
  c_st_capture: cover property (p_cv_st_capture);

  property p_cv_wake;
    @(posedge clock) disable iff (!nrst)
      $fell(power_down);
  endproperty
  c_wake: cover property (p_cv_wake);

  property p_cv_shut_frame;
    @(posedge sclk) disable iff (accel_select_n)
      rise_q.edge_cnt == EDGE_SAMPLE && cif.pm;
  endproperty
  c_shut_frame: cover property (p_cv_shut_frame);

  property p_cv_axis_y;
    @(posedge clock) disable iff (!nrst)
      capture && axis_s;
  endproperty
  c_axis_y: cover property (p_cv_axis_y);
endmodule

/* acm_pkg.sv */
// Shared constants for the dual-axis accelerometer serial readout
//
// Contract
// - Temperature select low frames temperature transfer
// - Output bits change on serial clock fall
// - Control input captured on serial clock rise
// - Self-test adds 205 LSB to result
// - Accel select low starts conversion, frames
// - Serial clock drives the conversion sequence
// - Sample taken on second rising edge; here it lands a few system clocks after that rise
// - Each conversion lasts sixteen serial clocks
// - Select rising returns output to high-Z
// - Select held low restarts conversion immediately
// - Control bit 7 is ignored
// - Bit 3 picks x (0) or y (1)
// - Bit 0 picks normal (0) or shutdown
// - Control contents kept during shutdown
// - New mode applies once control updates
// - Power-up on sixteenth rise after clearing
package acm_pkg;

  // ---------------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------------
  localparam int unsigned FRAME_EDGES = 16;        // Rises per conversion
  localparam int unsigned EDGE_W      = $clog2(FRAME_EDGES);
  localparam logic [EDGE_W-1:0] EDGE_SAMPLE   = 4'h1;  // Second rise
  localparam logic [EDGE_W-1:0] EDGE_CTRL_END = 4'h7;  // Eighth rise
  localparam logic [EDGE_W-1:0] EDGE_LAST     = 4'hF;  // Sixteenth rise
  localparam int unsigned DATA_W      = 12;        // Result width
  localparam int unsigned LEAD_BITS   = FRAME_EDGES - DATA_W;

  // ---------------------------------------------------------------------
  // Control word layout and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned CTRL_W   = 8;
  localparam int unsigned BIT_AXIS = 3;
  localparam int unsigned BIT_PM   = 0;
  localparam logic AXIS_RST = 1'b0;                // X axis after reset
  localparam logic PM_RST   = 1'b0;                // Normal after reset
  localparam logic OE_RST   = 1'b0;
  localparam logic DOUT_RST = 1'b0;

  // ---------------------------------------------------------------------
  // Self-test and timing
  // ---------------------------------------------------------------------
  localparam int unsigned ST_SHIFT_LSB  = 205;
  localparam int unsigned CLK_PERIOD_PS = 4000;    // 250 MHz
  localparam int unsigned RELEASE_NS    = 80;      // Output release max
  localparam int unsigned RELEASE_CYC   = RELEASE_NS * 1000 / CLK_PERIOD_PS;

endpackage

/* acm_ctl_if.sv */
// Control bundle between the frame logic and the control shifter
`timescale 1ns/1ns
interface acm_ctl_if;
  import acm_pkg::*;
  logic [EDGE_W-1:0] edge_idx;   // Index of the current serial rise
  logic              din;        // Serial input bit
  logic              axis;       // Axis choice, 1 = y
  logic              pm;         // Shutdown when high
  modport frame (output edge_idx, output din, input axis, input pm);
  modport ctrl  (input edge_idx, input din, output axis, output pm);
endinterface

/* acm_sync.sv */
// Two-flop level synchroniser, vector wide
`timescale 1ns/1ns
module acm_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import acm_pkg::*;

  // Both stages; first stage feeds only the second
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acm_sync_state_t;

  acm_sync_state_t st_q;
  acm_sync_state_t st_d;

  // Shift the chain; no reset, it flushes in two edges
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign q = st_q.s2;
endmodule

/* acm_ctrl_shift.sv */
// Control word shifter and mode register on the serial clock
`timescale 1ns/1ns
module acm_ctrl_shift (
  // Serial clock and async clear
  input wire logic sclk,
  input wire logic link_clr,
  // Frame side bundle
  acm_ctl_if.ctrl  cif
);
  import acm_pkg::*;

  // Shift bits, mode bits and pending wake-up
  typedef struct packed {
    logic [CTRL_W-2:0] sh;
    logic              axis;
    logic              pm;
    logic              pend_up;
  } acm_ctl_state_t;

  acm_ctl_state_t st_q;
  acm_ctl_state_t st_d;
  logic [CTRL_W-1:0] word;

  // Assemble word on the eighth rise, MSB first
  always_comb begin
    st_d = st_q;
    word = {st_q.sh, cif.din};
    if (cif.edge_idx < EDGE_CTRL_END) begin
      st_d.sh = {st_q.sh[CTRL_W-3:0], cif.din};
    end else if (cif.edge_idx == EDGE_CTRL_END) begin
      // Only axis and power bits matter; fixed bits ignored
      st_d.axis = word[BIT_AXIS];
      if (word[BIT_PM]) begin
        st_d.pm      = 1'b1;
        st_d.pend_up = 1'b0;
      end else if (st_q.pm) begin
        st_d.pend_up = 1'b1;
      end
    end else if (cif.edge_idx == EDGE_LAST && st_q.pend_up) begin
      st_d.pm      = 1'b0;
      st_d.pend_up = 1'b0;
    end
  end

  // Mode survives shutdown; only system reset clears it
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      st_q <= '{sh: '0, axis: AXIS_RST, pm: PM_RST, pend_up: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.axis = st_q.axis;
  assign cif.pm   = st_q.pm;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_axis_load;
    @(posedge sclk) disable iff (link_clr)
      cif.edge_idx == EDGE_CTRL_END |=> st_q.axis == $past(st_q.sh[2]);
  endproperty
  a_axis_load: assert property (p_axis_load)
    else $error("axis bit not loaded from control word");

  property p_wake;
    @(posedge sclk) disable iff (link_clr)
      st_q.pend_up && cif.edge_idx == EDGE_LAST |=> !st_q.pm;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no power-up on sixteenth rise");

  property p_sleep;
    @(posedge sclk) disable iff (link_clr)
      cif.edge_idx == EDGE_CTRL_END && cif.din |=> st_q.pm && !st_q.pend_up;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("shutdown not entered");
endmodule

/* acm_host_model.sv */
// Host serial master model for the accelerometer readout link
`timescale 1ns/1ns
module acm_host_model #(
  parameter int unsigned HALF_NS = 10  // Half period of the serial clock
) (
  // Serial pins driven by the host
  output logic      sclk,
  output logic      accel_select_n,
  output logic      temp_select_n,
  output logic      din,
  // Device data pin and its enable
  input  wire logic dout,
  input  wire logic dout_oe
);
  logic [15:0] rx [4];  // Words seen, one per conversion
  logic        oe_err;  // Enable wrong at some sample point
  logic        pin_q;   // Last level read off the data pin

  // Idle pins: clock parked low, both selects high
  initial begin
    sclk           = 1'b0;
    temp_select_n  = 1'b1;
    din            = 1'b0;
    pin_q          = 1'b0;
    oe_err         = 1'b0;
    // Raise the select after time zero so the select-high clear edge of the frame flops is seen
    #1;
    accel_select_n = 1'b1;
  end

  // One framed transfer of n conversions; temp picks the other select
  // No sensor settling is modelled, so rate advice is moot here
  task automatic frame(input logic [7:0] w, input int n, input bit temp);
    logic lvl;
    oe_err = 1'b0;
    // Only one select is ever lowered at a time
    if (temp) begin
      temp_select_n = 1'b0;
    end else begin
      accel_select_n = 1'b0;
    end
    din = w[7];
    // Odd lead keeps serial edges off the system clock edges
    #(HALF_NS + 1);
    for (int c = 0; c < n; c++) begin
      for (int k = 0; k < 16; k++) begin
        sclk = 1'b1;
        #(HALF_NS);
        sclk = 1'b0;
        // Word MSB first on rises 0..7, a toggling pattern after that
        din = (k < 7) ? w[6-k] : ((k == 15) ? w[7] : ~din);
        #(HALF_NS - 1);
        // A released pin shows the inverse of its last level
        lvl = dout_oe ? dout : ~pin_q;
        pin_q = lvl;
        rx[c][15-k] = lvl;
        if (dout_oe !== !temp) begin
          oe_err = 1'b1;
        end
        #1;
      end
    end
    accel_select_n = 1'b1;
    temp_select_n  = 1'b1;
    din            = ~din;
  endtask
endmodule

/* test_dual_axis_accel_serial_readout.sv */
// Self-checking bench for the accelerometer serial readout
`timescale 1ns/1ns
module test_dual_axis_accel_serial_readout;
  import acm_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic              clock;         // 250 MHz system clock
  logic              nrst;          // Synchronous reset, active low
  logic              sclk;          // Serial clock from the host
  logic              accel_select_n;
  logic              temp_select_n;
  logic              din;
  logic              dout;
  logic              dout_oe;
  logic              power_down;
  logic [DATA_W-1:0] accel_x;       // Sensor front end values
  logic [DATA_W-1:0] accel_y;
  logic              self_test_in;
  int                fails;         // Mismatch counter
  int                compares;      // Comparison counter

  // Clock generator
  initial clock = 1'b0;
  always #2 clock = ~clock;

  // Serial period of 12 ns; the result is back one rise early
  acm_host_model #(.HALF_NS(6)) host (
    .sclk           (sclk),
    .accel_select_n (accel_select_n),
    .temp_select_n  (temp_select_n),
    .din            (din),
    .dout           (dout),
    .dout_oe        (dout_oe)
  );

  acm_readout DUT (
    .clock          (clock),
    .nrst           (nrst),
    .sclk           (sclk),
    .accel_select_n (accel_select_n),
    .temp_select_n  (temp_select_n),
    .din            (din),
    .dout           (dout),
    .dout_oe        (dout_oe),
    .accel_x        (accel_x),
    .accel_y        (accel_y),
    .self_test_in   (self_test_in),
    .power_down     (power_down)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Compare and count
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  // Expected frame word: leading zeros then the result, MSB first
  function automatic logic [15:0] res(logic [DATA_W-1:0] v);
    return {{LEAD_BITS{1'b0}}, v};
  endfunction

  // After a frame: pin released within a bounded wait, then idle gap
  task automatic settle();
    int n;
    n = 0;
    while (dout_oe !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    chk("oe released", 16'h0, {15'h0, dout_oe});
    chk("dout idle", 16'h0, {15'h0, dout});
    repeat (8) @(negedge clock);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Axis choice lands on the next request and survives the frame gap
  task automatic t_axis();
    host.frame(8'h8C, 3, 1'b0);
    chk("oe in frame", 16'h0, {15'h0, host.oe_err});
    chk("conv0 old axis", res(accel_x), host.rx[0]);
    chk("conv1 y", res(accel_y), host.rx[1]);
    chk("conv2 y", res(accel_y), host.rx[2]);
    settle();
    host.frame(8'h04, 2, 1'b0);
    chk("kept axis", res(accel_y), host.rx[0]);
    chk("conv1 x", res(accel_x), host.rx[1]);
    settle();
    $display("test axis done");
  endtask

  // Value present before the second rise is the one converted
  task automatic t_sample();
    fork
      host.frame(8'h04, 1, 1'b0);
      begin
        #12;
        @(negedge clock);
        accel_x = 12'h5A5;
        #60;
        @(negedge clock);
        accel_x = 12'h3C3;
      end
    join
    chk("sample point", res(12'h5A5), host.rx[0]);
    settle();
    $display("test sample done");
  endtask

  // Self-test offset, with wrap past full scale
  task automatic t_self();
    @(negedge clock);
    accel_x      = 12'hF80;
    self_test_in = 1'b1;
    repeat (6) @(negedge clock);
    host.frame(8'h04, 1, 1'b0);
    chk("self test", res(12'h04D), host.rx[0]);
    settle();
    self_test_in = 1'b0;
    repeat (6) @(negedge clock);
    $display("test self done");
  endtask

  // Shutdown at once, wake only on the sixteenth rise
  task automatic t_power();
    accel_x = 12'h2B7;
    host.frame(8'h05, 2, 1'b0);
    chk("shut data", 16'h0, host.rx[1]);
    settle();
    chk("pd flag", 16'h1, {15'h0, power_down});
    host.frame(8'h04, 2, 1'b0);
    chk("no early wake", 16'h0, host.rx[0]);
    chk("woke data", res(12'h2B7), host.rx[1]);
    settle();
    chk("pd cleared", 16'h0, {15'h0, power_down});
    $display("test power done");
  endtask

  // Temperature frame never enables the accelerometer output
  task automatic t_temp();
    host.frame(8'h00, 1, 1'b1);
    chk("temp oe", 16'h0, {15'h0, host.oe_err});
    settle();
    $display("test temp done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    fails        = 0;
    compares     = 0;
    nrst         = 1'b0;
    accel_x      = 12'h123;
    accel_y      = 12'hABC;
    self_test_in = 1'b0;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    chk("reset oe", 16'h0, {15'h0, dout_oe});
    chk("reset pd", 16'h0, {15'h0, power_down});
    $display("test reset done");
    t_axis();
    t_sample();
    t_self();
    t_power();
    t_temp();
    wrap_up();
  end

  // Watchdog: the tests need about 3 us
  initial begin
    #50000;
    $display("CHECK FAILED watchdog expected 0 seen 1");
    fails++;
    wrap_up();
  end
endmodule
